//--- hdl/adcsq_pkg.sv
// Package for the converter channel sequencer.
// Assumes one 200 MHz clock; all users reference names with adcsq_pkg::.
package adcsq_pkg;
	// ==========================================================
	// Geometry
	localparam int NCH = 16;
	localparam int NCH_DEF = 8;
	localparam int RES_W = 12;
	localparam int CH_W = 5;
	localparam int SMP_W = 8;
	// ==========================================================
	// Timing
	localparam int CLK_MHZ = 200;
	localparam int CONV_MAX_MHZ = 18;
	localparam int CONV_MIN_CLKS = 18;
	// Core clock divider: ceil(200/18) keeps conversion clock <= 18 MHz
	localparam int CONV_DIV = (CLK_MHZ + CONV_MAX_MHZ - 1) / CONV_MAX_MHZ;
	localparam int CONV_CYC = CONV_DIV * CONV_MIN_CLKS;
	localparam int CNT_W = 12;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_CHEN = 8'h01;
	localparam logic [7:0] A_LOW = 8'h02;
	localparam logic [7:0] A_HIGH = 8'h03;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_INT = 8'h05;
	localparam logic [7:0] A_INTCLR = 8'h06;
	localparam logic [7:0] A_INTEN = 8'h07;
	localparam logic [7:0] A_FWCH = 8'h08;
	localparam logic [7:0] A_SMP0 = 8'h10;
	localparam logic [7:0] A_RES0 = 8'h30;
	// ==========================================================
	// Reset values
	localparam logic [15:0] CHEN_RST = 16'h00FF;
	localparam logic [SMP_W-1:0] SMP_RST = 8'h04;
	localparam logic [RES_W-1:0] HIGH_RST = 12'hFFF;
	// CTRL bits
	localparam int C_START = 0;
	localparam int C_CONT = 1;
	localparam int C_FW = 2;
	localparam int C_REF0 = 3;
	localparam int C_TEMP = 5;
	localparam int C_WIDE = 6;
	localparam int C_STOP = 7;
	// Interrupt bits and temperature channel index
	localparam int I_RANGE = 0;
	localparam int I_SCAN = 1;
	localparam int I_DONE = 2;
	localparam int CH_TEMP = 16;

	typedef enum logic [1:0] {
		REF_VDD = 2'b00,
		REF_HALF = 2'b01,
		REF_BG = 2'b10,
		REF_EXT = 2'b11
	} adcsq_ref_t;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_SAMP = 2'b01,
		S_CONV = 2'b10
	} adcsq_st_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} adcsq_bus_t;

	typedef struct packed {
		logic [CH_W-1:0] ch;
		logic sample;
		logic conv_clk;
		adcsq_ref_t refsel;
	} adcsq_core_t;
endpackage

//--- hdl/adcsq_top.sv
// Channel sequencer and result store for a 12-bit converter core.
// Assumes core result pins are asynchronous, valid while core_done is high.
//
// Function
// R1 - A conversion lasts at least 18 converter clocks of at most 18 MHz.
// R2 - Eight channels are scanned by default, up to sixteen when widened.
// R3 - A scan runs through enabled channels back to back, with no idle gap.
// R4 - Channels advance by the state machine or by firmware command.
// R5 - Every channel keeps its own result register.
// R6 - Every channel has its own sample time, used when it is sampled.
// R7 - Each result is checked against low and high limits for an interrupt.
// R8 - The range interrupt fires as the offending conversion ends.
// R9 - A field selects the supply, half supply, bandgap or external reference.
// R10 - Conversions are not started while the high-speed clock is absent.
// R11 - The temperature sensor can be picked as a conversion input.
// R12 - After the last channel a scan-complete event fires, then restart or stop.
`timescale 1ns/1ps
`default_nettype none
module adcsq_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire adcsq_pkg::adcsq_bus_t bus,
	output logic [15:0] rdata,
	// Power state: high-speed clock present
	input wire logic hf_ok,
	// Converter core
	output adcsq_pkg::adcsq_core_t core,
	input wire logic core_done,
	input wire logic [adcsq_pkg::RES_W-1:0] core_result,
	// Interrupt
	output logic irq
);
	// ==========================================================
	// Input synchronisers
	logic [1:0] done_s_r;
	logic [1:0] hf_s_r;
	logic [adcsq_pkg::RES_W-1:0] res_m_r;
	logic [adcsq_pkg::RES_W-1:0] res_s_r;
	logic done_d_r;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			done_s_r <= 2'h0;
			hf_s_r <= 2'h0;
			res_m_r <= '0;
			res_s_r <= '0;
			done_d_r <= 1'b0;
		end else begin
			done_s_r <= {done_s_r[0], core_done};
			hf_s_r <= {hf_s_r[0], hf_ok};
			res_m_r <= core_result;
			res_s_r <= res_m_r;
			done_d_r <= done_s_r[1];
		end
	end
	logic done_ev;
	assign done_ev = done_s_r[1] & ~done_d_r;

	// ==========================================================
	// Configuration registers
	logic [7:0] ctrl_r;
	logic [15:0] chen_r;
	logic [adcsq_pkg::RES_W-1:0] low_r;
	logic [adcsq_pkg::RES_W-1:0] high_r;
	logic [2:0] inten_r;
	logic [adcsq_pkg::CH_W-1:0] fwch_r;
	logic fw_go_r;
	logic [adcsq_pkg::SMP_W-1:0] smp_r [adcsq_pkg::NCH+1];
	logic [adcsq_pkg::RES_W-1:0] res_r [adcsq_pkg::NCH+1];
	logic wr_ctrl;
	assign wr_ctrl = bus.wr && bus.addr == adcsq_pkg::A_CTRL;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_r <= 8'h00;
			chen_r <= adcsq_pkg::CHEN_RST;
			low_r <= '0;
			high_r <= adcsq_pkg::HIGH_RST;
			inten_r <= 3'h0;
			fwch_r <= '0;
			fw_go_r <= 1'b0;
		end else begin
			fw_go_r <= 1'b0;
			if (wr_ctrl) begin
				ctrl_r <= bus.wdata[7:0];
			end else if (bus.wr && bus.addr == adcsq_pkg::A_CHEN) begin
				chen_r <= bus.wdata;
			end else if (bus.wr && bus.addr == adcsq_pkg::A_LOW) begin
				low_r <= bus.wdata[adcsq_pkg::RES_W-1:0];
			end else if (bus.wr && bus.addr == adcsq_pkg::A_HIGH) begin
				high_r <= bus.wdata[adcsq_pkg::RES_W-1:0];
			end else if (bus.wr && bus.addr == adcsq_pkg::A_INTEN) begin
				inten_r <= bus.wdata[2:0];
			end else if (bus.wr && bus.addr == adcsq_pkg::A_FWCH) begin
				// R4 firmware channel command
				fwch_r <= bus.wdata[adcsq_pkg::CH_W-1:0];
				fw_go_r <= 1'b1;
			end
		end
	end

	// R6 per-channel sample time
	genvar gi;
	generate
		for (gi = 0; gi <= adcsq_pkg::NCH; gi++) begin : g_ch
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					smp_r[gi] <= adcsq_pkg::SMP_RST;
				end else if (bus.wr && bus.addr ==
					adcsq_pkg::A_SMP0 + 8'(gi)) begin
					smp_r[gi] <= bus.wdata[adcsq_pkg::SMP_W-1:0];
				end
			end
		end
	endgenerate

	// ==========================================================
	// Sequencer
	adcsq_pkg::adcsq_st_t st_r;
	logic [adcsq_pkg::CH_W-1:0] ch_r;
	logic [adcsq_pkg::CNT_W-1:0] cnt_r;
	logic run_r;
	logic [3:0] div_r;
	logic cclk_r;
	logic scan_ev;
	logic [adcsq_pkg::CH_W-1:0] nxt_ch;
	logic nxt_ok;
	logic [adcsq_pkg::CH_W-1:0] first_ch;
	logic first_ok;
	logic [16:0] en_mask;

	// R2 R11 channel set, eight or sixteen plus temperature
	always_comb begin
		en_mask = {ctrl_r[adcsq_pkg::C_TEMP],
			ctrl_r[adcsq_pkg::C_WIDE] ? chen_r[15:8] : 8'h00,
			chen_r[7:0]};
	end

	// R3 next enabled channel after the current one
	always_comb begin
		nxt_ch = '0;
		nxt_ok = 1'b0;
		first_ch = '0;
		first_ok = 1'b0;
		for (int i = adcsq_pkg::NCH; i >= 0; i--) begin
			if (en_mask[i]) begin
				first_ch = adcsq_pkg::CH_W'(i);
				first_ok = 1'b1;
				if (i > int'(ch_r)) begin
					nxt_ch = adcsq_pkg::CH_W'(i);
					nxt_ok = 1'b1;
				end
			end
		end
	end

	// R1 conversion clock divided to at most 18 MHz
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_r <= 4'h0;
			cclk_r <= 1'b0;
		end else if (div_r == 4'(adcsq_pkg::CONV_DIV / 2 - 1)) begin
			div_r <= 4'h0;
			cclk_r <= ~cclk_r;
		end else begin
			div_r <= div_r + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r <= adcsq_pkg::S_IDLE;
			ch_r <= '0;
			cnt_r <= '0;
			run_r <= 1'b0;
			scan_ev <= 1'b0;
		end else begin
			scan_ev <= 1'b0;
			if (wr_ctrl && bus.wdata[adcsq_pkg::C_STOP]) begin
				run_r <= 1'b0;
			end
			case (st_r)
				adcsq_pkg::S_IDLE: begin
					// R10 no start without high-speed clock
					if (hf_s_r[1] && fw_go_r) begin
						ch_r <= fwch_r;
						cnt_r <= adcsq_pkg::CNT_W'(smp_r[fwch_r]);
						st_r <= adcsq_pkg::S_SAMP;
					end else if (hf_s_r[1] && wr_ctrl && first_ok &&
						bus.wdata[adcsq_pkg::C_START] &&
						!bus.wdata[adcsq_pkg::C_FW]) begin
						run_r <= 1'b1;
						ch_r <= first_ch;
						cnt_r <= adcsq_pkg::CNT_W'(smp_r[first_ch]);
						st_r <= adcsq_pkg::S_SAMP;
					end
				end
				adcsq_pkg::S_SAMP: begin
					if (!hf_s_r[1]) begin
						st_r <= adcsq_pkg::S_IDLE;
						run_r <= 1'b0;
					end else if (cnt_r == '0) begin
						// R1 hold at least 18 converter clocks
						cnt_r <= adcsq_pkg::CNT_W'(adcsq_pkg::CONV_CYC);
						st_r <= adcsq_pkg::S_CONV;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				default: begin
					if (cnt_r != '0) begin
						cnt_r <= cnt_r - 1'b1;
					end else if (done_ev) begin
						// R10 no further channel once the clock is lost
						if (!run_r || ctrl_r[adcsq_pkg::C_FW] || !hf_s_r[1]) begin
							st_r <= adcsq_pkg::S_IDLE;
							run_r <= 1'b0;
						end else if (nxt_ok) begin
							// R3 straight into next sample
							ch_r <= nxt_ch;
							cnt_r <= adcsq_pkg::CNT_W'(smp_r[nxt_ch]);
							st_r <= adcsq_pkg::S_SAMP;
						end else begin
							// R12 scan complete, restart or stop
							scan_ev <= 1'b1;
							if (ctrl_r[adcsq_pkg::C_CONT] && hf_s_r[1]) begin
								ch_r <= first_ch;
								cnt_r <= adcsq_pkg::CNT_W'(smp_r[first_ch]);
								st_r <= adcsq_pkg::S_SAMP;
							end else begin
								st_r <= adcsq_pkg::S_IDLE;
								run_r <= 1'b0;
							end
						end
					end
				end
			endcase
		end
	end

	logic take;
	assign take = st_r == adcsq_pkg::S_CONV && cnt_r == '0 && done_ev;

	// R5 result buffer per channel
	generate
		for (gi = 0; gi <= adcsq_pkg::NCH; gi++) begin : g_res
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					res_r[gi] <= '0;
				end else if (take && ch_r == adcsq_pkg::CH_W'(gi)) begin
					res_r[gi] <= res_s_r;
				end
			end
		end
	endgenerate

	// ==========================================================
	// Interrupts
	logic [2:0] ev;
	logic [2:0] int_r;
	always_comb begin
		ev = 3'h0;
		// R7 R8 limit check on each completed value
		ev[adcsq_pkg::I_RANGE] = take && (res_s_r < low_r || res_s_r > high_r);
		ev[adcsq_pkg::I_SCAN] = scan_ev;
		ev[adcsq_pkg::I_DONE] = take;
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			int_r <= 3'h0;
			irq <= 1'b0;
		end else begin
			// Set wins over a simultaneous clear
			if (bus.wr && bus.addr == adcsq_pkg::A_INTCLR) begin
				int_r <= (int_r & ~bus.wdata[2:0]) | ev;
			end else begin
				int_r <= int_r | ev;
			end
			irq <= |((int_r | ev) & inten_r);
		end
	end

	// ==========================================================
	// Core outputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			core <= '0;
		end else begin
			core.ch <= ch_r;
			core.sample <= st_r == adcsq_pkg::S_SAMP;
			core.conv_clk <= cclk_r;
			// R9 reference select
			core.refsel <= adcsq_pkg::adcsq_ref_t'(ctrl_r[4:3]);
		end
	end

	// ==========================================================
	// Read port, unmapped reads zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata <= 16'h0000;
		end else if (!bus.rd) begin
			rdata <= 16'h0000;
		end else if (bus.addr == adcsq_pkg::A_CTRL) begin
			rdata <= {8'h00, ctrl_r};
		end else if (bus.addr == adcsq_pkg::A_CHEN) begin
			rdata <= chen_r;
		end else if (bus.addr == adcsq_pkg::A_LOW) begin
			rdata <= {4'h0, low_r};
		end else if (bus.addr == adcsq_pkg::A_HIGH) begin
			rdata <= {4'h0, high_r};
		end else if (bus.addr == adcsq_pkg::A_STAT) begin
			rdata <= {8'h00, run_r, st_r, ch_r};
		end else if (bus.addr == adcsq_pkg::A_INT) begin
			rdata <= {13'h0000, int_r};
		end else if (bus.addr == adcsq_pkg::A_INTEN) begin
			rdata <= {13'h0000, inten_r};
		end else if (bus.addr >= adcsq_pkg::A_SMP0 &&
			bus.addr <= adcsq_pkg::A_SMP0 + 8'h10) begin
			rdata <= {8'h00, smp_r[5'(bus.addr - adcsq_pkg::A_SMP0)]};
		end else if (bus.addr >= adcsq_pkg::A_RES0 &&
			bus.addr <= adcsq_pkg::A_RES0 + 8'h10) begin
			rdata <= {4'h0, res_r[5'(bus.addr - adcsq_pkg::A_RES0)]};
		end else begin
			rdata <= 16'h0000;
		end
	end
endmodule
`default_nettype wire

//--- bench/adcsq_core_model.sv
// Behavioural converter core facing the sequencer.
// Assumes one clock shared with the sequencer and a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module adcsq_core_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Sequencer side
	input wire adcsq_pkg::adcsq_core_t core,
	output logic core_done,
	output logic [11:0] core_result
);
	logic [8:0] cnt;
	logic [2:0] dcnt;
	logic busy;
	logic [11:0] val;
	// Released result line shows a wrong value, never the held one
	assign core_result = core_done ? val : ~val;
	// conversion time, reference and channel in result
	always @(posedge clk) begin
		if (!rst_n) begin
			cnt <= 9'h000;
			dcnt <= 3'h0;
			busy <= 1'b0;
			core_done <= 1'b0;
			val <= 12'h000;
		end else begin
			if (core.sample) begin
				cnt <= 9'h000;
				busy <= 1'b1;
			end else if (busy) begin
				cnt <= cnt + 9'h001;
			end
			if (core_done) begin
				dcnt <= dcnt + 3'h1;
				if (dcnt == 3'h7)
					core_done <= 1'b0;
			end else if (busy && !core.sample && cnt == 9'h0E6) begin
				core_done <= 1'b1;
				busy <= 1'b0;
				dcnt <= 3'h0;
				val <= {core.ch[3:0], 6'h29, core.refsel};
			end
		end
	end
endmodule
`default_nettype wire

//--- bench/adcsq_top_assertions.sv
// Port checker for the sequencer top, attached by bind.
// Assumes the core holds core_done high for at least five cycles.
`timescale 1ns/1ps
`default_nettype none
module adcsq_top_assertions (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Watched ports
	input wire adcsq_pkg::adcsq_bus_t bus,
	input wire logic [15:0] rdata,
	input wire logic hf_ok,
	input wire adcsq_pkg::adcsq_core_t core,
	input wire logic core_done,
	input wire logic irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [11:0] gap_r;
	logic seen_r;
	// ==========================================================
	// Idle time between sample phases, saturating
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gap_r <= 12'h000;
			seen_r <= 1'b0;
		end else begin
			gap_r <= core.sample ? 12'h000 : gap_r + {11'h000, gap_r != 12'hFFF};
			seen_r <= seen_r | core.sample;
		end
	end
	// ==========================================================
	// Checks
	rdata_idle_a: assert property (!$past(bus.rd) |-> rdata == 16'h0000)
		else $error("read data outside the answer cycle");
	conv_clk_rate_a: assert property ($rose(core.conv_clk) |=> core.conv_clk[*5])
		else $error("converter clock high phase too short");
	conv_len_a: assert property ($rose(core.sample) && seen_r |-> gap_r >= adcsq_pkg::CONV_CYC)
		else $error("conversion phase shorter than minimum");
	no_clk_start_a: assert property ((!hf_ok)[*4] |=> !$rose(core.sample))
		else $error("sampling began without high-speed clock");
	irq_cause_a: assert property ($rose(irq) |-> core_done)
		else $error("interrupt rose away from a conversion end");
	ch_hold_a: assert property (core.sample && $past(core.sample) |-> $stable(core.ch))
		else $error("channel moved while sampling");
	ch_range_a: assert property (core.sample |-> core.ch <= 5'h10)
		else $error("channel beyond temperature input");
	ref_write_a: assert property (!$stable(core.refsel) |->
		($past(bus.wr) && $past(bus.addr) == adcsq_pkg::A_CTRL) ||
		($past(bus.wr, 2) && $past(bus.addr, 2) == adcsq_pkg::A_CTRL))
		else $error("reference changed without a control write");
endmodule
bind adcsq_top adcsq_top_assertions u_chk (.clk(clk), .rst_n(rst_n),
	.bus(bus), .rdata(rdata), .hf_ok(hf_ok), .core(core),
	.core_done(core_done), .irq(irq));
`default_nettype wire

//--- bench/adc_channel_sequencer_tb.sv
// Self-checking bench for the sequencer with a behavioural core.
// Assumes the core model result pattern {ch, 6'h29, ref}.
`timescale 1ns/1ps
`default_nettype none
module adc_channel_sequencer_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hf_ok = 1'b1;
	adcsq_pkg::adcsq_bus_t bus = '0;
	logic [15:0] rdata;
	adcsq_pkg::adcsq_core_t core;
	logic core_done;
	logic [11:0] core_result;
	logic irq;
	logic [7:0] wcnt = 8'h00;
	logic [7:0] wid [0:16];
	int n_errors = 0;
	int checked = 0;
	always #2.5 clk = ~clk;
	adcsq_top DUT (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
		.hf_ok(hf_ok), .core(core), .core_done(core_done),
		.core_result(core_result), .irq(irq));
	adcsq_core_model u_core (.clk(clk), .rst_n(rst_n), .core(core),
		.core_done(core_done), .core_result(core_result));
	// Sample phase width per channel
	always @(posedge clk) begin
		wcnt <= core.sample ? wcnt + 8'h01 : 8'h00;
		if ($fell(core.sample))
			wid[$past(core.ch)] <= wcnt;
	end
	// ==========================================================
	// Helpers
	function automatic logic [11:0] res_of(input int c, input logic [1:0] r);
		return {4'(c), 6'h29, r};
	endfunction
	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		bus <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 chk(rdata, e);
		@(posedge clk);
	endtask
	// Looks after the edge: the interrupt output lags a clear or mask by one
	task automatic wait_irq();
		int i;
		i = 0;
		#1;
		while (i < 8000 && irq !== 1'b1) begin
			@(posedge clk);
			#1;
			i++;
		end
		if (i == 8000) begin
			n_errors++;
			final_report();
		end
		@(posedge clk);
	endtask
	task automatic run_scan(input logic [15:0] chen, input logic [15:0] ctl);
		logic [11:0] lo;
		logic [11:0] hi;
		logic rng;
		logic en;
		logic [7:0] sm [0:16];
		lo = 12'($urandom_range(0, 2047));
		hi = lo + 12'($urandom_range(0, 1536));
		rng = 1'b0;
		wr(adcsq_pkg::A_INTCLR, 16'h0007);
		wr(adcsq_pkg::A_INTEN, 16'h0002);
		wr(adcsq_pkg::A_CHEN, chen);
		wr(adcsq_pkg::A_LOW, {4'h0, lo});
		wr(adcsq_pkg::A_HIGH, {4'h0, hi});
		for (int c = 0; c < 17; c++) begin
			sm[c] = 8'($urandom_range(1, 20));
			wr(adcsq_pkg::A_SMP0 + 8'(c), {8'h00, sm[c]});
		end
		wr(adcsq_pkg::A_CTRL, ctl | 16'h0001);
		wait_irq();
		for (int c = 0; c < 17; c++) begin
			en = (c < 8) ? chen[c] : (c < 16) ? ctl[6] & chen[c] : ctl[5];
			if (en) begin
				rd(adcsq_pkg::A_RES0 + 8'(c), {4'h0, res_of(c, 2'b00)});
				chk({8'h00, wid[c]}, {8'h00, sm[c] + 8'h01});
				rng = rng | (res_of(c, 2'b00) < lo) | (res_of(c, 2'b00) > hi);
			end
		end
		rd(adcsq_pkg::A_INT, {13'h0000, 2'b11, rng});
		wr(adcsq_pkg::A_INTCLR, 16'h0007);
		repeat (2) @(posedge clk);
		#1 chk({15'h0000, irq}, 16'h0000);
		@(posedge clk);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(8642));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(adcsq_pkg::A_CHEN, 16'h00FF);
		rd(adcsq_pkg::A_HIGH, 16'h0FFF);
		rd(adcsq_pkg::A_SMP0 + 8'h03, 16'h0004);
		rd(8'h60, 16'h0000);
		for (int r = 0; r < 4; r++) begin
			wr(adcsq_pkg::A_CTRL, 16'(r << 3));
			#1 chk({14'h0000, core.refsel}, 16'(r));
			@(posedge clk);
		end
		wr(adcsq_pkg::A_CTRL, 16'h0000);
		hf_ok <= 1'b0;
		repeat (4) @(posedge clk);
		wr(adcsq_pkg::A_CTRL, 16'h0001);
		repeat (10) @(posedge clk);
		#1 chk({15'h0000, core.sample}, 16'h0000);
		hf_ok <= 1'b1;
		repeat (4) @(posedge clk);
		run_scan(16'($urandom) | 16'h0001, 16'h0000);
		run_scan(16'h8101, 16'h0060);
		run_scan(16'h0080, 16'h0000);
		// Range event must beat the end of the scan
		wr(adcsq_pkg::A_LOW, 16'h0100);
		wr(adcsq_pkg::A_HIGH, 16'h0FFF);
		wr(adcsq_pkg::A_CHEN, 16'h0003);
		wr(adcsq_pkg::A_INTEN, 16'h0001);
		wr(adcsq_pkg::A_CTRL, 16'h0001);
		wait_irq();
		rd(adcsq_pkg::A_INT, 16'h0005);
		wr(adcsq_pkg::A_INTEN, 16'h0002);
		wait_irq();
		wr(adcsq_pkg::A_INTCLR, 16'h0007);
		wr(adcsq_pkg::A_INTEN, 16'h0004);
		wr(adcsq_pkg::A_CTRL, 16'h001C);
		wr(adcsq_pkg::A_FWCH, 16'h0005);
		wait_irq();
		rd(adcsq_pkg::A_RES0 + 8'h05, {4'h0, res_of(5, 2'b11)});
		// Continuous scan restarts until told to stop
		wr(adcsq_pkg::A_INTCLR, 16'h0007);
		wr(adcsq_pkg::A_CHEN, 16'h0001);
		wr(adcsq_pkg::A_INTEN, 16'h0002);
		wr(adcsq_pkg::A_CTRL, 16'h0003);
		rd(adcsq_pkg::A_STAT, 16'h00A0);
		wait_irq();
		wr(adcsq_pkg::A_INTCLR, 16'h0007);
		wait_irq();
		rd(adcsq_pkg::A_INT, 16'h0007);
		wr(adcsq_pkg::A_CTRL, 16'h0080);
		repeat (300) @(posedge clk);
		rd(adcsq_pkg::A_STAT, 16'h0000);
		final_report();
	end
endmodule
`default_nettype wire
